// *** hw/port3_pin_function.sv ***
// pin function, reset state and clock output for the two-bit port 3
//
// Contract
// R1 - during reset both port latches sit in input-only mode with pull-up off.
// R2 - each pin keeps its own output-type setting, independent of the other.
// R3 - with clock_out_enable set, port3_bit0 carries the cpu clock divided by two.
// R4 - clock output only from rc, watchdog or external clock, never with rtc on the crystal.
// R5 - a crystal option in the flash configuration hands port3_bit0 to the amplifier output.
// R6 - when configured, port3_bit1 feeds the oscillator and clock generator input.
// R7 - port3_bit1 is a port pin only on rc or watchdog clock with the rtc not on the crystal.
// R8 - software never touches undefined special function register addresses.
// R9 - software uses each defined register only for its purpose.
// R10 - reserved bits are written zero and may read back anything.
// R11 - bits fixed at zero are written zero and always read zero.
// R12 - bits fixed at one are written one and always read one.
// R13 - the half-rate clock is a toggle flop, 50 percent duty, port function when off.
// R14 - pin function priority is oscillator, then clock output, then port latch.
`timescale 1ns/1ns
module port3_pin_function
    import port3_pin_pkg::*;
#(
    parameter int WIDTH = port3_pin_pkg::PORT_WIDTH
)
(
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rstn,
    // flash configuration and clock selection
    input  wire port3_pin_pkg::clk_src_t      cpu_clk_src,
    input  wire logic                         xtal_for_rtc,
    input  wire logic                         osc_in_select,
    // trim register write port and readback
    input  wire logic                         trim_we,
    input  wire logic [7:0]                   trim_wdata,
    output logic      [7:0]                   trim_rdata,
    // port latch and output type writes
    input  wire logic                         latch_we,
    input  wire logic [WIDTH-1:0]             latch_wdata,
    input  wire logic [WIDTH-1:0]             mode_we,
    input  wire logic [1:0]                   mode_wdata,
    // pin sensing
    input  wire logic [WIDTH-1:0]             pin_in,
    output logic      [WIDTH-1:0]             pin_sync,
    // pin drive
    output logic      [WIDTH-1:0]             pin_out,
    output logic      [WIDTH-1:0]             pin_oe,
    output logic      [WIDTH-1:0]             pin_pullup,
    // oscillator hookup and half-rate clock output
    output logic                              osc_in_pin,
    output logic                              osc_in_valid,
    input  wire logic                         osc_amp_out,
    output logic                              half_rate_clock_output
);
    import port3_pin_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [1:0]       mode_q [WIDTH];
    logic [WIDTH-1:0] latch_q;
    logic [7:0]       trim_q;
    logic [WIDTH-1:0] sync1_q;
    logic [WIDTH-1:0] sync2_q;
    logic             toggle_q;
    logic             amp1_q;
    logic             amp2_q;
    logic             in_reset;

    // legal register image after fixed and reserved bits
    function automatic logic [7:0] sfr_image(input logic [7:0] v);
        sfr_image = (v & ~(RESERVED_MASK | FIXED0_MASK)) | FIXED1_MASK;
    endfunction

    logic crystal_mode;
    logic clock_out_allowed;
    logic bit1_is_port;
    logic clock_out_on;
    assign crystal_mode      = (cpu_clk_src == SRC_XTAL);                    // [R5]
    assign clock_out_allowed = (cpu_clk_src != SRC_XTAL) && !xtal_for_rtc;   // [R4]
    assign bit1_is_port      = ((cpu_clk_src == SRC_RC) || (cpu_clk_src == SRC_WDOG))
                               && !xtal_for_rtc && !osc_in_select;          // [R7]
    assign clock_out_on      = trim_q[CLOCK_OUT_ENABLE_BIT] && clock_out_allowed; // [R3]

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
            trim_q <= TRIM_RESET;
        else if (trim_we)
            trim_q <= sfr_image(trim_wdata);                               // [R11] [R12]
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            trim_rdata <= sfr_image(TRIM_RESET) | RESERVED_VALUE;
        else
            trim_rdata <= sfr_image(trim_q) | (RESERVED_VALUE & RESERVED_MASK); // [R10]
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            latch_q <= {WIDTH{LATCH_RESET}};
        else if (latch_we)
            latch_q <= latch_wdata;
    end

    for (genvar i = 0; i < WIDTH; i++)
    begin : g_mode
        always_ff @(posedge clk)
        begin
            if (!rstn)
                mode_q[i] <= MODE_RESET;                                   // [R1]
            else if (mode_we[i])
                mode_q[i] <= mode_wdata;                                   // [R2]
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            in_reset <= 1'b1;
        else
            in_reset <= 1'b0;
    end

    // ----------------------------------------
    // half-rate clock
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn || !clock_out_on)
            toggle_q <= 1'b0;
        else
            toggle_q <= ~toggle_q;                                         // [R13]
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            half_rate_clock_output <= 1'b0;
        else
            half_rate_clock_output <= toggle_q;
    end

    // ----------------------------------------
    // input synchroniser
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            amp1_q  <= 1'b0;
            amp2_q  <= 1'b0;
        end
        else
        begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            amp1_q  <= osc_amp_out;
            amp2_q  <= amp1_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pin_sync     <= '0;
            osc_in_pin   <= 1'b0;
            osc_in_valid <= 1'b0;
        end
        else
        begin
            pin_sync     <= sync2_q;
            osc_in_pin   <= sync2_q[BIT1];                                 // [R6]
            osc_in_valid <= osc_in_select || crystal_mode;                 // [R6]
        end
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    function automatic logic port_oe(input logic [1:0] m, input logic d);
        unique case (m)
            MODE_QUASI:     port_oe = !d;
            MODE_PUSHPULL:  port_oe = 1'b1;
            MODE_INPUT:     port_oe = 1'b0;
            MODE_OPENDRAIN: port_oe = !d;
        endcase
    endfunction

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pin_out    <= '0;
            pin_oe     <= '0;                                              // [R1]
            pin_pullup <= {WIDTH{PULLUP_RESET}};                           // [R1]
        end
        else
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                pin_out[i]    <= latch_q[i];
                pin_oe[i]     <= port_oe(mode_q[i], latch_q[i]);
                pin_pullup[i] <= (mode_q[i] == MODE_QUASI) && !in_reset;
            end
            if (crystal_mode)                                              // [R14] [R5]
            begin
                pin_out[BIT0]    <= amp2_q;
                pin_oe[BIT0]     <= 1'b1;
                pin_pullup[BIT0] <= 1'b0;
            end
            else if (clock_out_on)                                         // [R14] [R3]
            begin
                pin_out[BIT0]    <= toggle_q;
                pin_oe[BIT0]     <= 1'b1;
                pin_pullup[BIT0] <= 1'b0;
            end
            if (!bit1_is_port)                                             // [R14] [R7]
            begin
                pin_out[BIT1]    <= 1'b0;
                pin_oe[BIT1]     <= 1'b0;
                pin_pullup[BIT1] <= 1'b0;
            end
        end
    end

endmodule // port3_pin_function

// *** hw/port3_pin_pkg.sv ***
// constants for the port 3 pin function block
package port3_pin_pkg;
    localparam int          PORT_WIDTH     = 2;
    localparam int          BIT0           = 0;
    localparam int          BIT1           = 1;
    localparam int          CLOCK_OUT_ENABLE_BIT = 6;
    localparam logic [1:0]  MODE_RESET     = 2'h2;  // input only
    localparam logic        PULLUP_RESET   = 1'b0;
    localparam logic        LATCH_RESET    = 1'b1;
    localparam logic [7:0]  TRIM_RESET     = 8'h00;
    localparam logic [7:0]  RESERVED_MASK  = 8'h00; // bits marked '-'
    localparam logic [7:0]  FIXED0_MASK    = 8'h00; // bits marked '0'
    localparam logic [7:0]  FIXED1_MASK    = 8'h00; // bits marked '1'
    localparam logic [7:0]  RESERVED_VALUE = 8'h00;
    // output-type codes per pin
    localparam logic [1:0]  MODE_QUASI     = 2'h0;
    localparam logic [1:0]  MODE_PUSHPULL  = 2'h1;
    localparam logic [1:0]  MODE_INPUT     = 2'h2;
    localparam logic [1:0]  MODE_OPENDRAIN = 2'h3;
    // cpu clock source selection
    typedef enum logic [1:0] {
        SRC_RC,
        SRC_WDOG,
        SRC_EXT,
        SRC_XTAL
    } clk_src_t;
endpackage

// *** dv/port3_pin_chk.sv ***
// assertions for the port 3 pin function block
`timescale 1ns/1ns
module port3_pin_chk
    import port3_pin_pkg::*;
#(
    parameter int WIDTH = 2
)
(
    // clock, reset and selection
    input wire logic                    clk,
    input wire logic                    rstn,
    input wire port3_pin_pkg::clk_src_t cpu_clk_src,
    input wire logic                    xtal_for_rtc,
    input wire logic                    osc_in_select,
    // register and pin side
    input wire logic                    trim_we,
    input wire logic [7:0]              trim_wdata,
    input wire logic [7:0]              trim_rdata,
    input wire logic                    latch_we,
    input wire logic [WIDTH-1:0]        pin_out,
    input wire logic [WIDTH-1:0]        pin_oe,
    input wire logic [WIDTH-1:0]        pin_pullup,
    input wire logic                    osc_in_valid,
    input wire logic                    half_rate_clock_output
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic en, ok, p1;
    logic [7:0] img;
    assign en = trim_rdata[CLOCK_OUT_ENABLE_BIT];
    assign ok = cpu_clk_src != SRC_XTAL && !xtal_for_rtc;
    assign p1 = (cpu_clk_src == SRC_RC || cpu_clk_src == SRC_WDOG) && !xtal_for_rtc
        && !osc_in_select;
    assign img = (trim_wdata & ~FIXED0_MASK) | FIXED1_MASK;
    rst_idle_a: assert property (
        disable iff (1'b0) !rstn |=> pin_pullup == '0 && pin_oe == '0)
        else $error("pins active in reset");
    half_rate_run_a: assert property (
        (en && ok)[*3] |-> half_rate_clock_output != $past(half_rate_clock_output))
        else $error("clock output not toggling");
    half_rate_block_a: assert property (
        (!ok && cpu_clk_src != SRC_XTAL && !latch_we)[*3] |-> $stable(pin_out[0]))
        else $error("clock output while blocked");
    xtal_bit0_a: assert property ((cpu_clk_src == SRC_XTAL)[*3] |-> pin_oe[0])
        else $error("bit0 not driven by amplifier");
    osc_route_a: assert property (osc_in_select[*3] |-> osc_in_valid)
        else $error("oscillator input not routed");
    bit1_port_a: assert property ((!p1)[*3] |-> !pin_oe[1])
        else $error("bit1 driven as port");
    trim_write_a: assert property (
        trim_we ##1 (!trim_we)[*3] |-> ((trim_rdata ^ $past(img, 3)) & ~RESERVED_MASK) == 8'h00)
        else $error("trim readback wrong");
    fixed_bits_a: assert property ($past(rstn) |->
        (trim_rdata & FIXED0_MASK) == 8'h00 && (trim_rdata & FIXED1_MASK) == FIXED1_MASK)
        else $error("fixed bit wrong");
    cover property (en && ok);
    cover property (cpu_clk_src == SRC_XTAL);
    cover property (osc_in_select && trim_we);
endmodule // port3_pin_chk

bind port3_pin_function port3_pin_chk #(.WIDTH(WIDTH)) chk (.clk(clk), .rstn(rstn),
    .cpu_clk_src(cpu_clk_src), .xtal_for_rtc(xtal_for_rtc), .osc_in_select(osc_in_select),
    .trim_we(trim_we), .trim_wdata(trim_wdata), .trim_rdata(trim_rdata), .latch_we(latch_we),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .osc_in_valid(osc_in_valid),
    .half_rate_clock_output(half_rate_clock_output));

// *** dv/xtal_board_model.sv ***
// crystal and board model at the port 3 pins
`timescale 1ns/1ns
module xtal_board_model
(
    // clock and crystal run
    input  wire logic       clk,
    input  wire logic       run,
    // pin drive from the block
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    input  wire logic [1:0] pin_pullup,
    // pin levels and amplifier
    output logic      [1:0] pin_in,
    output logic            osc_amp_out
);
    logic [1:0] cnt_q  = 2'h0;
    logic [1:0] last_q = 2'h0;
    logic       osc_q  = 1'h0;
    always_ff @(posedge clk)
    begin
        cnt_q <= cnt_q + 2'h1;
        if (run && cnt_q == 2'h3)
            osc_q <= !osc_q; // crystal only while selected
        for (int i = 0; i < 2; i++)
            if (pin_oe[i])
                last_q[i] <= pin_out[i];
    end
    // released pin: pull-up level, else the inverse of what was last driven
    assign osc_amp_out = run ? osc_q : 1'h0;
    assign pin_in[0] = pin_oe[0] ? pin_out[0] : (pin_pullup[0] | !last_q[0]);
    assign pin_in[1] = pin_oe[1] ? pin_out[1] : (pin_pullup[1] | !last_q[1]);
endmodule // xtal_board_model

// *** dv/port3_pin_function_tb.sv ***
// testbench for the port 3 pin function block
`timescale 1ns/1ns
module port3_pin_function_tb;
    import port3_pin_pkg::*;
    typedef struct packed {clk_src_t src; logic rtc, sel, en, tog, p1;} row_t;
    logic clk = 1'h0, rstn, rtc, sel, trim_we, latch_we, osc_amp_out, osc_in_pin;
    logic osc_in_valid, hro, p0, ph;
    logic [7:0] trim_wdata, trim_rdata, n, h;
    logic [1:0] latch_wdata, mode_we, mode_wdata, pin_in, pin_sync, pin_out, pin_oe, pin_pullup;
    clk_src_t src;
    int num_errors = 0, num_checks = 0, cycles = 0;
    row_t rows [7] = '{
        '{SRC_RC,   1'h0, 1'h0, 1'h1, 1'h1, 1'h1},
        '{SRC_WDOG, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1},
        '{SRC_EXT,  1'h0, 1'h0, 1'h1, 1'h1, 1'h0},
        '{SRC_XTAL, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0},
        '{SRC_RC,   1'h1, 1'h0, 1'h1, 1'h0, 1'h0},
        '{SRC_RC,   1'h0, 1'h1, 1'h1, 1'h1, 1'h0},
        '{SRC_RC,   1'h0, 1'h0, 1'h0, 1'h0, 1'h1}};
    port3_pin_function uut (.clk(clk), .rstn(rstn), .cpu_clk_src(src), .xtal_for_rtc(rtc),
        .osc_in_select(sel), .trim_we(trim_we), .trim_wdata(trim_wdata), .trim_rdata(trim_rdata),
        .latch_we(latch_we), .latch_wdata(latch_wdata), .mode_we(mode_we), .mode_wdata(mode_wdata),
        .pin_in(pin_in), .pin_sync(pin_sync), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .osc_in_pin(osc_in_pin), .osc_in_valid(osc_in_valid),
        .osc_amp_out(osc_amp_out), .half_rate_clock_output(hro));
    xtal_board_model board (.clk(clk), .run(src == SRC_XTAL), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .pin_in(pin_in), .osc_amp_out(osc_amp_out));
    always #5 clk = ~clk;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic twr(input logic [7:0] d); // defined trim register, whole byte d as given
        trim_we = 1'h1;
        trim_wdata = d;
        cyc(1);
        trim_we = 1'h0;
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            end_sim;
        end
    end
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        {rstn, rtc, sel, trim_we, latch_we, latch_wdata, mode_we, mode_wdata} = '0;
        trim_wdata = 8'h00;
        src = SRC_RC;
        cyc(5);
        rstn = 1'h1;
        chk({6'h00, pin_pullup | pin_oe}, 8'h00);
        chk(trim_rdata, TRIM_RESET);
        {mode_we, mode_wdata, latch_we} = {2'h3, MODE_PUSHPULL, 1'h1};
        cyc(1);
        {mode_we, latch_we} = '0;
        foreach (rows[i])
        begin
            {src, rtc, sel} = {rows[i].src, rows[i].rtc, rows[i].sel};
            twr({7'h00, rows[i].en} << CLOCK_OUT_ENABLE_BIT);
            cyc(4);
            n = 8'h00;
            h = 8'h00;
            repeat (4)
            begin
                p0 = pin_out[0];
                ph = hro;
                cyc(1);
                n = n + {7'h00, pin_out[0] !== p0};
                h = h + {7'h00, hro !== ph};
            end
            chk({7'h00, n == 8'h04}, {7'h00, rows[i].tog});
            chk(h, rows[i].tog ? 8'h04 : 8'h00);
            chk({7'h00, pin_oe[1]}, {7'h00, rows[i].p1});
        end
        {latch_we, latch_wdata} = {1'h1, 2'h3};
        cyc(1);
        latch_we = 1'h0;
        cyc(5);
        chk({6'h00, pin_sync}, 8'h03);
        chk({7'h00, osc_in_pin}, 8'h01);
        {mode_we, mode_wdata} = {2'h1, MODE_OPENDRAIN};
        cyc(1);
        {mode_we, mode_wdata} = {2'h2, MODE_QUASI};
        cyc(1);
        mode_we = 2'h0;
        cyc(5);
        chk({6'h00, pin_oe}, 8'h00);
        chk({6'h00, pin_pullup}, 8'h02);
        chk({6'h00, pin_sync}, 8'h02);
        {mode_we, mode_wdata, latch_we, latch_wdata} = {2'h1, MODE_INPUT, 1'h1, 2'h1};
        cyc(1);
        {mode_we, latch_we} = '0;
        cyc(3);
        chk({6'h00, pin_oe}, 8'h02);
        src = SRC_XTAL;
        cyc(4);
        chk({7'h00, pin_oe[0]}, 8'h01);
        twr(8'hff);
        cyc(3);
        chk(trim_rdata & ~RESERVED_MASK, (~FIXED0_MASK | FIXED1_MASK) & ~RESERVED_MASK);
        rstn = 1'h0;
        cyc(2);
        chk({6'h00, pin_pullup | pin_oe}, 8'h00);
        rstn = 1'h1;
        cyc(1);
        chk(trim_rdata, TRIM_RESET);
        end_sim;
    end
endmodule // port3_pin_function_tb
